// File: logic/usbh_top.sv
// USB host front end: attach and speed detection, event routing, endpoint buffers, DMA.
//
// The register addresses and the Wishbone register port were chosen for this implementation.
`include "usbh_consts.svh"
module usbh_top
  import usbh_pkg::*;
#(
  parameter int EVT_N = `USBH_EVT_COUNT,
  parameter int BLKW = `USBH_BLK_WIDTH
) (
  // Clock and reset.
  input wire logic clk_i,
  input wire logic rst_i,
  // Wishbone slave.
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [7:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  // Line state from the transceiver.
  input wire logic dp_i,
  input wire logic dm_i,
  // Packet engine events: bit 0 CRC, 1 toggle, 2 timeout, 3..8 other.
  input wire logic [EVT_N-3:0] engine_evt_i,
  // Packet engine byte streams.
  input wire logic lnk_rx_valid_i,
  input wire logic [7:0] lnk_rx_data_i,
  output logic lnk_rx_ready_o,
  input wire logic lnk_pkt_end_i,
  input wire logic lnk_tx_ready_i,
  output logic lnk_tx_valid_o,
  output logic [7:0] lnk_tx_data_o,
  // Line and engine control.
  output logic dplus_pulldown_on_o,
  output logic dminus_pulldown_on_o,
  output logic host_run_o,
  output logic attached_o,
  output logic full_speed_o,
  // DMA and interrupts.
  output logic [1:0] dma_request_signal_o,
  output logic low_priority_irq_line_o,
  output logic medium_priority_irq_line_o,
  output logic high_priority_irq_line_o
);

  localparam logic [7:0] CFG_OFF [2] = '{`USBH_OFF_EP1_CFG, `USBH_OFF_EP2_CFG};
  localparam logic [7:0] BLK_OFF [2] = '{`USBH_OFF_EP1_BLK, `USBH_OFF_EP2_BLK};
  localparam logic [7:0] DAT_OFF [2] = '{`USBH_OFF_EP1_DATA, `USBH_OFF_EP2_DATA};
  localparam int CW = 9;

  ////////////////////////////////////////////////////////////////////////////
  // Declarations.

  logic ack_q;
  logic [31:0] dat_q;
  logic req;
  logic wr_acc;
  logic rd_go;
  logic [31:0] wmask;
  logic [31:0] rd_val;
  logic [1:0] cfg_a_q;
  logic halt_q;
  logic [1:0] pwr_q;
  logic [EVT_N-1:0] flags_q;
  logic [EVT_N-1:0] mask_q;
  logic [2*EVT_N-1:0] lvl_q;
  logic [EVT_N-1:0] evt_set;
  logic [EVT_N-1:0] pending;
  logic [EVT_N-1:0] cause_lo;
  logic [EVT_N-1:0] cause_med;
  logic [EVT_N-1:0] cause_hi;
  logic [1:0] ep_dir_q;
  logic [1:0] ep_mode_q;
  logic [1:0] ep_init_q;
  logic [BLKW-1:0] blk_q [2];
  logic [1:0] dma_on_q;
  logic [1:0] dp_s_q;
  logic [1:0] dm_s_q;
  logic se0;
  usbh_attach_t st_q;
  logic [CW-1:0] cnt_q;
  logic att_q;
  logic fs_q;
  logic cand_fs_q;
  logic att_pulse_q;
  logic det_pulse_q;
  logic rx_ep;
  logic tx_ep;
  logic [7:0] head [2];
  logic [1:0] ep_full;
  logic [1:0] ep_empty;

  ////////////////////////////////////////////////////////////////////////////
  // Wishbone slave: ack one cycle after the strobe, writes land on the ack edge.

  assign req = wb_cyc_i && wb_stb_i;
  assign wr_acc = req && ack_q && wb_we_i;
  assign rd_go = req && !ack_q && !wb_we_i;
  assign wb_ack_o = ack_q;
  assign wb_dat_o = dat_q;

  // Byte enables widened to a bit mask.
  always_comb begin
    for (int b = 0; b < 4; b++) begin
      wmask[8*b +: 8] = {8{wb_sel_i[b]}};
    end
  end

  // Acknowledge strobe, dropped the cycle after.
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ack_q <= 1'b0;
    end else begin
      ack_q <= req && !ack_q;
    end
  end

  // Read data captured in the request cycle; unmapped offsets read zero.
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      dat_q <= '0;
    end else if (rd_go) begin
      dat_q <= rd_val;
    end
  end

  // Read multiplexer.
  always_comb begin
    rd_val = '0;
    if (wb_adr_i == `USBH_OFF_CFG_A) begin
      rd_val[1:0] = cfg_a_q;
    end else if (wb_adr_i == `USBH_OFF_CFG_B) begin
      rd_val[0] = halt_q;
    end else if (wb_adr_i == `USBH_OFF_POWER) begin
      rd_val[1:0] = pwr_q;
    end else if (wb_adr_i == `USBH_OFF_STATE) begin
      rd_val[`USBH_STATE_ATTACH] = att_q;
      rd_val[`USBH_STATE_SPEED] = att_q && fs_q;
    end else if (wb_adr_i == `USBH_OFF_FLAGS) begin
      rd_val[EVT_N-1:0] = flags_q;
    end else if (wb_adr_i == `USBH_OFF_MASK) begin
      rd_val[EVT_N-1:0] = mask_q;
    end else if (wb_adr_i == `USBH_OFF_LEVEL) begin
      rd_val[2*EVT_N-1:0] = lvl_q;
    end else if (wb_adr_i == `USBH_OFF_CAUSE_LO) begin
      rd_val[EVT_N-1:0] = cause_lo;
    end else if (wb_adr_i == `USBH_OFF_CAUSE_MED) begin
      rd_val[EVT_N-1:0] = cause_med;
    end else if (wb_adr_i == `USBH_OFF_CAUSE_HI) begin
      rd_val[EVT_N-1:0] = cause_hi;
    end else if (wb_adr_i == `USBH_OFF_DMA_ON) begin
      rd_val[1:0] = dma_on_q;
    end else begin
      for (int k = 0; k < 2; k++) begin
        if (wb_adr_i == CFG_OFF[k]) begin
          rd_val[`USBH_EP_DIR] = ep_dir_q[k];
          rd_val[`USBH_EP_DMA_MODE] = ep_mode_q[k];
          rd_val[`USBH_EP_INIT] = ep_init_q[k];
        end else if (wb_adr_i == BLK_OFF[k]) begin
          rd_val[BLKW-1:0] = blk_q[k];
        end else if (wb_adr_i == DAT_OFF[k]) begin
          rd_val[7:0] = head[k];
        end
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Control registers.

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      cfg_a_q <= '0;
      halt_q <= `USBH_CFG_B_RESET;
      pwr_q <= '0;
    end else if (wr_acc && wb_sel_i[0]) begin
      if (wb_adr_i == `USBH_OFF_CFG_A) begin
        cfg_a_q <= wb_dat_i[1:0];
      end else if (wb_adr_i == `USBH_OFF_CFG_B) begin
        halt_q <= wb_dat_i[0];
      end else if (wb_adr_i == `USBH_OFF_POWER) begin
        pwr_q <= wb_dat_i[1:0];
      end
    end
  end

  assign host_run_o = cfg_a_q[`USBH_CFG_A_HOST] && cfg_a_q[`USBH_CFG_A_ENABLE] && !halt_q;
  assign dplus_pulldown_on_o = pwr_q[`USBH_POWER_DP];
  assign dminus_pulldown_on_o = pwr_q[`USBH_POWER_DM];

  // Mask and level select, byte-lane writes.
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      mask_q <= '0;
      lvl_q <= '0;
    end else if (wr_acc) begin
      if (wb_adr_i == `USBH_OFF_MASK) begin
        mask_q <= (mask_q & ~wmask[EVT_N-1:0]) | (wb_dat_i[EVT_N-1:0] & wmask[EVT_N-1:0]);
      end else if (wb_adr_i == `USBH_OFF_LEVEL) begin
        lvl_q <= (lvl_q & ~wmask[2*EVT_N-1:0]) | (wb_dat_i[2*EVT_N-1:0] & wmask[2*EVT_N-1:0]);
      end
    end
  end

  // direction, mode and init bits per endpoint.
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ep_dir_q <= {`USBH_EP2_DIR_RESET, `USBH_EP1_DIR_RESET};
      ep_mode_q <= '0;
      ep_init_q <= '0;
      dma_on_q <= '0;
      for (int k = 0; k < 2; k++) begin
        blk_q[k] <= '0;
      end
    end else if (wr_acc) begin
      if (wb_adr_i == `USBH_OFF_DMA_ON && wb_sel_i[0]) begin
        dma_on_q <= wb_dat_i[1:0];
      end
      for (int k = 0; k < 2; k++) begin
        if (wb_adr_i == CFG_OFF[k] && wb_sel_i[0]) begin
          ep_dir_q[k] <= wb_dat_i[`USBH_EP_DIR];
          ep_mode_q[k] <= wb_dat_i[`USBH_EP_DMA_MODE];
          ep_init_q[k] <= wb_dat_i[`USBH_EP_INIT];
        end
        if (wb_adr_i == BLK_OFF[k]) begin
          blk_q[k] <= (blk_q[k] & ~wmask[BLKW-1:0]) | (wb_dat_i[BLKW-1:0] & wmask[BLKW-1:0]);
        end
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Attach detection.

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      dp_s_q <= '0;
      dm_s_q <= '0;
    end else begin
      dp_s_q <= {dp_s_q[0], dp_i};
      dm_s_q <= {dm_s_q[0], dm_i};
    end
  end

  assign se0 = !dp_s_q[1] && !dm_s_q[1];

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      st_q <= USBH_DETACHED;
      cnt_q <= '0;
      att_q <= 1'b0;
      fs_q <= 1'b0;
      cand_fs_q <= 1'b0;
      att_pulse_q <= 1'b0;
      det_pulse_q <= 1'b0;
    end else begin
      att_pulse_q <= 1'b0;
      det_pulse_q <= 1'b0;
      case (st_q)
        USBH_DETACHED: begin
          cnt_q <= '0;
          cand_fs_q <= dp_s_q[1];
          if (host_run_o && !se0) begin
            st_q <= USBH_SETTLE;
          end
        end
        USBH_SETTLE: begin
          if (!host_run_o || se0 || cand_fs_q != dp_s_q[1]) begin
            st_q <= USBH_DETACHED;
          end else if (cnt_q == CW'(`USBH_ATTACH_CYC - 1)) begin
            // idle D+ high means full speed.
            st_q <= USBH_ATTACHED;
            att_q <= 1'b1;
            fs_q <= cand_fs_q;
            att_pulse_q <= 1'b1;
            cnt_q <= '0;
          end else begin
            cnt_q <= cnt_q + 1'b1;
          end
        end
        USBH_ATTACHED: begin
          if (!se0) begin
            cnt_q <= '0;
          end else begin
            cnt_q <= cnt_q + 1'b1;
          end
          if (!host_run_o || (se0 && cnt_q == CW'(`USBH_DETACH_CYC - 1))) begin
            st_q <= USBH_DETACHED;
            att_q <= 1'b0;
            det_pulse_q <= 1'b1;
          end
        end
        default: begin
          st_q <= USBH_DETACHED;
          att_q <= 1'b0;
        end
      endcase
    end
  end

  assign attached_o = att_q;
  assign full_speed_o = att_q && fs_q;

  ////////////////////////////////////////////////////////////////////////////
  // Event flags and interrupt routing.

  assign evt_set = {engine_evt_i, det_pulse_q, att_pulse_q};

  // write one clears, a new event wins.
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      flags_q <= '0;
    end else if (wr_acc && wb_adr_i == `USBH_OFF_FLAGS) begin
      flags_q <= (flags_q & ~(wb_dat_i[EVT_N-1:0] & wmask[EVT_N-1:0])) | evt_set;
    end else begin
      flags_q <= flags_q | evt_set;
    end
  end

  assign pending = flags_q & mask_q;

  always_comb begin
    for (int i = 0; i < EVT_N; i++) begin
      cause_lo[i] = pending[i] && lvl_q[2*i +: 2] == USBH_LVL_LO;
      cause_med[i] = pending[i] && lvl_q[2*i +: 2] == USBH_LVL_MED;
      cause_hi[i] = pending[i] && lvl_q[2*i +: 2] >= USBH_LVL_HI;
    end
  end

  assign low_priority_irq_line_o = |cause_lo;
  assign medium_priority_irq_line_o = |cause_med;
  assign high_priority_irq_line_o = |cause_hi;

  ////////////////////////////////////////////////////////////////////////////
  // Endpoint buffers.

  // endpoint 1 direction picks both roles.
  assign tx_ep = ep_dir_q[0] ? 1'b0 : 1'b1;
  assign rx_ep = ~tx_ep;
  assign lnk_rx_ready_o = !ep_full[rx_ep];
  assign lnk_tx_valid_o = !ep_empty[tx_ep];
  assign lnk_tx_data_o = head[tx_ep];

  // two buffers, 256 and 64 bytes.
  // first buffer holds a full packet.
  for (genvar k = 0; k < 2; k++) begin : g_ep
    logic is_rx;
    logic bus_wr;
    logic bus_rd;
    assign is_rx = (rx_ep == 1'(k));
    assign bus_wr = wr_acc && wb_adr_i == DAT_OFF[k] && wb_sel_i[0];
    assign bus_rd = rd_go && wb_adr_i == DAT_OFF[k];
    usbh_ep_buf #(
      .DEPTH((k == 0) ? `USBH_EP1_DEPTH : `USBH_EP2_DEPTH),
      .BLKW(BLKW)
    ) u_buf (
      .clk_i(clk_i),
      .rst_i(rst_i),
      .flush_i(ep_init_q[k]),
      .dir_out_i(ep_dir_q[k]),
      .dma_on_i(dma_on_q[k]),
      .pkt_mode_i(ep_mode_q[k]),
      .blk_load_i(wr_acc && wb_adr_i == BLK_OFF[k]),
      .blk_total_i((blk_q[k] & ~wmask[BLKW-1:0]) | (wb_dat_i[BLKW-1:0] & wmask[BLKW-1:0])),
      .push_i(is_rx ? lnk_rx_valid_i : bus_wr),
      .push_data_i(is_rx ? lnk_rx_data_i : wb_dat_i[7:0]),
      .pop_i(is_rx ? bus_rd : (lnk_tx_ready_i && tx_ep == 1'(k))),
      .pkt_end_i(lnk_pkt_end_i && is_rx),
      .bus_xfer_i(bus_wr || bus_rd),
      .head_o(head[k]),
      .full_o(ep_full[k]),
      .empty_o(ep_empty[k]),
      .dma_req_o(dma_request_signal_o[k])
    );
  end

endmodule // usbh_top

// File: logic/usbh_consts.svh
// Register offsets, field positions, reset values and timing counts of the USB host front end.
`ifndef USBH_CONSTS_SVH
`define USBH_CONSTS_SVH

// Register byte offsets.
`define USBH_OFF_CFG_A 8'h00
`define USBH_OFF_CFG_B 8'h04
`define USBH_OFF_POWER 8'h08
`define USBH_OFF_STATE 8'h0C
`define USBH_OFF_FLAGS 8'h10
`define USBH_OFF_MASK 8'h14
`define USBH_OFF_LEVEL 8'h18
`define USBH_OFF_CAUSE_LO 8'h1C
`define USBH_OFF_CAUSE_MED 8'h20
`define USBH_OFF_CAUSE_HI 8'h24
`define USBH_OFF_EP1_CFG 8'h28
`define USBH_OFF_EP2_CFG 8'h2C
`define USBH_OFF_EP1_BLK 8'h30
`define USBH_OFF_EP2_BLK 8'h34
`define USBH_OFF_DMA_ON 8'h38
`define USBH_OFF_EP1_DATA 8'h3C
`define USBH_OFF_EP2_DATA 8'h40

// Field positions.
`define USBH_CFG_A_HOST 0
`define USBH_CFG_A_ENABLE 1
`define USBH_POWER_DP 0
`define USBH_POWER_DM 1
`define USBH_STATE_ATTACH 0
`define USBH_STATE_SPEED 1
`define USBH_EP_DIR 0
`define USBH_EP_DMA_MODE 1
`define USBH_EP_INIT 2
`define USBH_EVT_ATTACH 0
`define USBH_EVT_DETACH 1

// Reset values.
`define USBH_CFG_B_RESET 1'h1
`define USBH_EP1_DIR_RESET 1'h1
`define USBH_EP2_DIR_RESET 1'h0

// Sizes.
`define USBH_EVT_COUNT 11
`define USBH_EP1_DEPTH 256
`define USBH_EP2_DEPTH 64
`define USBH_BLK_WIDTH 16

// Timing: line must hold a state this long before attach or removal is taken.
`define USBH_CLK_NS 10
`define USBH_ATTACH_NS 2500
`define USBH_DETACH_NS 2500
`define USBH_ATTACH_CYC ((`USBH_ATTACH_NS + `USBH_CLK_NS - 1) / `USBH_CLK_NS)
`define USBH_DETACH_CYC ((`USBH_DETACH_NS + `USBH_CLK_NS - 1) / `USBH_CLK_NS)

`endif

// File: logic/usbh_pkg.sv
// Types shared by the USB host front end.
package usbh_pkg;

  // Attach detector states, one-hot.
  typedef enum logic [2:0] {
    USBH_DETACHED = 3'b001,
    USBH_SETTLE = 3'b010,
    USBH_ATTACHED = 3'b100
  } usbh_attach_t;

  // Interrupt level codes in the level select register.
  typedef enum logic [1:0] {
    USBH_LVL_LO = 2'h0,
    USBH_LVL_MED = 2'h1,
    USBH_LVL_HI = 2'h2
  } usbh_level_t;

endpackage

// File: logic/usbh_ep_buf.sv
// One endpoint byte buffer with its DMA request logic.
`include "usbh_consts.svh"
module usbh_ep_buf #(
  parameter int DEPTH = 64,
  parameter int BLKW = 16
) (
  // Clock and reset.
  input wire logic clk_i,
  input wire logic rst_i,
  // Configuration.
  input wire logic flush_i,
  input wire logic dir_out_i,
  input wire logic dma_on_i,
  input wire logic pkt_mode_i,
  input wire logic blk_load_i,
  input wire logic [BLKW-1:0] blk_total_i,
  // Byte traffic.
  input wire logic push_i,
  input wire logic [7:0] push_data_i,
  input wire logic pop_i,
  input wire logic pkt_end_i,
  input wire logic bus_xfer_i,
  output logic [7:0] head_o,
  output logic full_o,
  output logic empty_o,
  output logic dma_req_o
);

  localparam int AW = $clog2(DEPTH);

  logic [7:0] mem_q [DEPTH];
  logic [AW-1:0] wp_q;
  logic [AW-1:0] rp_q;
  logic [AW:0] cnt_q;
  logic [BLKW-1:0] rem_q;
  logic pkt_rdy_q;
  logic do_push;
  logic do_pop;

  // Accesses that would overrun or underrun are dropped.
  assign do_push = push_i && !full_o;
  assign do_pop = pop_i && !empty_o;
  assign full_o = (cnt_q == (AW+1)'(DEPTH));
  assign empty_o = (cnt_q == '0);
  assign head_o = mem_q[rp_q];

  // Storage array.
  always_ff @(posedge clk_i) begin
    if (do_push) begin
      mem_q[wp_q] <= push_data_i;
    end
  end

  // Pointers and fill level; init empties the buffer.
  always_ff @(posedge clk_i) begin
    if (rst_i || flush_i) begin
      wp_q <= '0;
      rp_q <= '0;
      cnt_q <= '0;
    end else begin
      if (do_push) begin
        wp_q <= (wp_q == AW'(DEPTH - 1)) ? '0 : wp_q + 1'b1;
      end
      if (do_pop) begin
        rp_q <= (rp_q == AW'(DEPTH - 1)) ? '0 : rp_q + 1'b1;
      end
      cnt_q <= cnt_q + (AW+1)'(do_push) - (AW+1)'(do_pop);
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      rem_q <= '0;
    end else if (blk_load_i) begin
      rem_q <= blk_total_i;
    end else if (dma_on_i && bus_xfer_i && rem_q != '0) begin
      rem_q <= rem_q - 1'b1;
    end
  end

  // A finished packet stays ready until the buffer drains; a new end wins.
  always_ff @(posedge clk_i) begin
    if (rst_i || flush_i) begin
      pkt_rdy_q <= 1'b0;
    end else if (pkt_end_i) begin
      pkt_rdy_q <= 1'b1;
    end else if (empty_o) begin
      pkt_rdy_q <= 1'b0;
    end
  end

  always_comb begin
    dma_req_o = 1'b0;
    if (dma_on_i && rem_q != '0) begin
      if (dir_out_i) begin
        dma_req_o = !full_o;
      end else if (pkt_mode_i) begin
        dma_req_o = pkt_rdy_q && !empty_o;
      end else begin
        dma_req_o = !empty_o;
      end
    end
  end

endmodule // usbh_ep_buf

// File: bench/usbh_top_monitor.sv
// Concurrent checks on the ports of the USB host front end.
module usbh_top_monitor (
  // Clock and reset.
  input wire logic clk_i,
  input wire logic rst_i,
  // Register bus handshake.
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_ack_o,
  // Line and attach state.
  input wire logic dp_i,
  input wire logic dm_i,
  input wire logic host_run_o,
  input wire logic attached_o,
  input wire logic full_speed_o,
  // Transmit stream.
  input wire logic lnk_tx_ready_i,
  input wire logic lnk_tx_valid_o,
  input wire logic [7:0] lnk_tx_data_o
);
  timeunit 1ns;
  timeprecision 1ns;

  logic [8:0] se0_q;
  logic [8:0] live_q;

  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);

  ////////////////////////////////////////////////////////////////////////////////
  // Counts consecutive cycles of both lines low, saturating.
  always_ff @(posedge clk_i) begin
    if (rst_i || dp_i || dm_i) se0_q <= 9'h000;
    else if (se0_q != 9'h1FF) se0_q <= se0_q + 9'h001;
  end

  // Counts consecutive cycles with a line high, saturating.
  always_ff @(posedge clk_i) begin
    if (rst_i || !(dp_i || dm_i)) live_q <= 9'h000;
    else if (live_q != 9'h1FF) live_q <= live_q + 9'h001;
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Every request is answered after one wait cycle, and the answer is one cycle long.
  a_ack_answers: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
    else $error("bus request not acknowledged in time");
  a_ack_single: assert property (wb_ack_o |=> !wb_ack_o)
    else $error("acknowledge longer than one cycle");
  a_speed_attach: assert property (full_speed_o |-> attached_o)
    else $error("full speed shown while detached");
  a_attach_run: assert property ($rose(attached_o) |-> host_run_o)
    else $error("attach taken while host not running");
  a_attach_stable: assert property ($rose(attached_o) |-> live_q >= 9'h0F0)
    else $error("attach taken before the line settled");
  a_speed_dplus: assert property ($rose(attached_o) |=> full_speed_o == dp_i)
    else $error("speed does not follow the idle line");
  a_se0_detach: assert property (se0_q >= 9'h104 |-> !attached_o)
    else $error("still attached after a long idle-low line");
  a_halt_detach: assert property ($fell(host_run_o) |-> ##[0:3] !attached_o)
    else $error("still attached after host stopped");
  a_tx_hold: assert property (lnk_tx_valid_o && !lnk_tx_ready_i
    |=> lnk_tx_valid_o && $stable(lnk_tx_data_o))
    else $error("transmit byte changed while stalled");
endmodule // usbh_top_monitor

// File: bench/usbh_dev_model.sv
// Attached USB device model driving the D+ and D- line levels.
module usbh_dev_model (
  // Clock.
  input wire logic clk_i,
  // Attach command: 0 none, 1 low speed, 2 full speed.
  input wire logic [1:0] mode_i,
  // Line levels.
  output logic dp_o = 1'b0,
  output logic dm_o = 1'b0
);
  timeunit 1ns;
  timeprecision 1ns;

  // idle line level
  // Detached lines sit at the pull-down level; full speed idles D+ high, low speed D- high.
  always @(posedge clk_i) begin
    dp_o <= (mode_i == 2'h2);
    dm_o <= (mode_i == 2'h1);
  end
endmodule // usbh_dev_model

// File: bench/test_usbh_top.sv
// Self-checking testbench of the USB host front end.
`include "usbh_consts.svh"
module test_usbh_top;
  timeunit 1ns;
  timeprecision 1ns;
  logic clk_i = 1'b0;
  logic rst_i = 1'b1;
  logic wb_cyc_i = 1'b0;
  logic wb_stb_i = 1'b0;
  logic wb_we_i = 1'b0;
  logic [7:0] wb_adr_i = 8'h00;
  logic [3:0] wb_sel_i = 4'hF;
  logic [31:0] wb_dat_i = 32'h0;
  logic [31:0] wb_dat_o;
  logic wb_ack_o, dp_i, dm_i, lnk_rx_ready_o, lnk_tx_valid_o, dplus_pulldown_on_o;
  logic [8:0] engine_evt_i = 9'h000;
  logic lnk_rx_valid_i = 1'b0;
  logic [7:0] lnk_rx_data_i = 8'h00;
  logic lnk_pkt_end_i = 1'b0;
  logic lnk_tx_ready_i = 1'b0;
  logic [7:0] lnk_tx_data_o;
  logic dminus_pulldown_on_o, host_run_o, attached_o, full_speed_o;
  logic [1:0] dma_request_signal_o;
  logic low_priority_irq_line_o, medium_priority_irq_line_o, high_priority_irq_line_o;
  logic [1:0] dev_mode = 2'h0;
  int mismatches = 0;
  int checks_done = 0;
  int n;

  // Free-running 100 MHz clock.
  always #5 clk_i = ~clk_i;

  usbh_top uut (.clk_i, .rst_i, .wb_cyc_i, .wb_stb_i, .wb_we_i, .wb_adr_i, .wb_sel_i,
    .wb_dat_i, .wb_dat_o, .wb_ack_o, .dp_i, .dm_i, .engine_evt_i, .lnk_rx_valid_i,
    .lnk_rx_data_i, .lnk_rx_ready_o, .lnk_pkt_end_i, .lnk_tx_ready_i, .lnk_tx_valid_o,
    .lnk_tx_data_o, .dplus_pulldown_on_o, .dminus_pulldown_on_o, .host_run_o, .attached_o,
    .full_speed_o, .dma_request_signal_o, .low_priority_irq_line_o,
    .medium_priority_irq_line_o, .high_priority_irq_line_o);
  usbh_dev_model dev (.clk_i(clk_i), .mode_i(dev_mode), .dp_o(dp_i), .dm_o(dm_i));

  ////////////////////////////////////////////////////////////////////////////////
  // Compares a seen value with the expected one.
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    checks_done++;
    if (seen !== exp) begin
      mismatches++;
      $display("ERROR at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  // One classic bus cycle, released at the edge where acknowledge is seen.
  task automatic xfer(input logic we, input logic [7:0] a, input logic [31:0] d,
                      output logic [31:0] q);
    @(posedge clk_i);
    wb_cyc_i <= 1'b1;
    wb_stb_i <= 1'b1;
    wb_we_i <= we;
    wb_adr_i <= a;
    wb_dat_i <= d;
    @(posedge clk_i);
    // Waits for the answer however long it takes; only the watchdog ends a hang.
    while (wb_ack_o !== 1'b1) begin
      @(posedge clk_i);
    end
    q = wb_dat_o;
    wb_cyc_i <= 1'b0;
    wb_stb_i <= 1'b0;
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] q;
    xfer(1'b1, a, d, q);
  endtask

  task automatic rchk(input logic [7:0] a, input logic [31:0] e);
    logic [31:0] q;
    xfer(1'b0, a, 32'h0, q);
    chk(q, e);
  endtask

  // Polls a register until any bit of the mask shows, within a bounded count.
  task automatic wait_bit(input logic [7:0] a, input logic [31:0] m);
    logic [31:0] q;
    int k;
    k = 0;
    q = 32'h0;
    while ((q & m) === 32'h0 && k < 400) begin
      xfer(1'b0, a, 32'h0, q);
      k++;
    end
    chk(q & m, m);
  endtask

  task automatic test_done();
    $display("Checks made: %0d, mismatches: %0d", checks_done, mismatches);
    if (mismatches == 0 && checks_done > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask

  ////////////////////////////////////////////////////////////////////////////////
  // Main sequence.
  initial begin
    repeat (3) @(posedge clk_i);
    rst_i <= 1'b0;
    rchk(`USBH_OFF_CFG_B, 32'h1);
    rchk(`USBH_OFF_STATE, 32'h0);
    rchk(8'h80, 32'h0);
    wr(`USBH_OFF_POWER, 32'h3);
    wr(`USBH_OFF_CFG_A, 32'h3);
    wr(`USBH_OFF_CFG_B, 32'h0);
    wr(`USBH_OFF_MASK, 32'h0);
    @(posedge clk_i);
    chk({dplus_pulldown_on_o, dminus_pulldown_on_o, host_run_o}, 32'h7);
    $display("Test setup done");
    dev_mode <= 2'h2;
    wait_bit(`USBH_OFF_FLAGS, 32'h1);
    rchk(`USBH_OFF_STATE, 32'h3);
    chk({high_priority_irq_line_o, medium_priority_irq_line_o, low_priority_irq_line_o}, 0);
    wr(`USBH_OFF_MASK, 32'h1);
    for (int i = 0; i < 4; i++) begin
      wr(`USBH_OFF_LEVEL, i);
      @(posedge clk_i);
      chk({high_priority_irq_line_o, medium_priority_irq_line_o, low_priority_irq_line_o},
          32'h1 << (i > 2 ? 2 : i));
      rchk(`USBH_OFF_CAUSE_LO + 8'h4 * (i > 2 ? 2 : i), 32'h1);
    end
    wr(`USBH_OFF_FLAGS, 32'h1);
    rchk(`USBH_OFF_FLAGS, 32'h0);
    chk({high_priority_irq_line_o, medium_priority_irq_line_o, low_priority_irq_line_o}, 0);
    $display("Test attach done");
    dev_mode <= 2'h0;
    wait_bit(`USBH_OFF_FLAGS, 32'h2);
    rchk(`USBH_OFF_STATE, 32'h0);
    wr(`USBH_OFF_FLAGS, 32'h7FF);
    dev_mode <= 2'h1;
    wait_bit(`USBH_OFF_FLAGS, 32'h1);
    rchk(`USBH_OFF_STATE, 32'h1);
    wr(`USBH_OFF_CFG_B, 32'h1);
    rchk(`USBH_OFF_STATE, 32'h0);
    dev_mode <= 2'h0;
    wr(`USBH_OFF_CFG_B, 32'h0);
    wr(`USBH_OFF_FLAGS, 32'h7FF);
    $display("Test detach done");
    for (int i = 0; i < 9; i++) begin
      @(posedge clk_i);
      engine_evt_i <= 9'h001 << i;
      @(posedge clk_i);
      engine_evt_i <= 9'h000;
      rchk(`USBH_OFF_FLAGS, 32'h4 << i);
      wr(`USBH_OFF_FLAGS, 32'h4 << i);
    end
    $display("Test events done");
    wr(`USBH_OFF_EP1_BLK, 32'h2);
    @(posedge clk_i);
    chk(dma_request_signal_o, 32'h0);
    wr(`USBH_OFF_DMA_ON, 32'h1);
    @(posedge clk_i);
    chk(dma_request_signal_o, 32'h1);
    for (int i = 0; i < 256; i++) begin
      wr(`USBH_OFF_EP1_DATA, i);
      if (i == 1) begin
        @(posedge clk_i);
        chk(dma_request_signal_o, 32'h0);
        wr(`USBH_OFF_DMA_ON, 32'h0);
      end
    end
    chk(lnk_tx_valid_o, 32'h1);
    lnk_tx_ready_i <= 1'b1;
    n = 0;
    repeat (300) begin
      @(posedge clk_i);
      if (lnk_tx_valid_o === 1'b1) begin
        chk(lnk_tx_data_o, n[7:0]);
        n++;
      end
    end
    lnk_tx_ready_i <= 1'b0;
    chk(n, 32'd256);
    lnk_rx_valid_i <= 1'b1;
    n = 0;
    repeat (80) begin
      @(posedge clk_i);
      if (lnk_rx_ready_o === 1'b1) begin
        n++;
        lnk_rx_data_i <= n[7:0];
      end
    end
    lnk_rx_valid_i <= 1'b0;
    chk(n, 32'd64);
    wr(`USBH_OFF_EP2_BLK, 32'd64);
    wr(`USBH_OFF_DMA_ON, 32'h2);
    @(posedge clk_i);
    chk(dma_request_signal_o, 32'h2);
    wr(`USBH_OFF_EP2_CFG, 32'h2);
    @(posedge clk_i);
    chk(dma_request_signal_o, 32'h0);
    lnk_pkt_end_i <= 1'b1;
    @(posedge clk_i);
    lnk_pkt_end_i <= 1'b0;
    @(posedge clk_i);
    chk(dma_request_signal_o, 32'h2);
    for (int i = 0; i < 64; i++) rchk(`USBH_OFF_EP2_DATA, i);
    @(posedge clk_i);
    chk(dma_request_signal_o, 32'h0);
    $display("Test buffers done");
    test_done();
  end

  // Watchdog well beyond the expected run length.
  initial begin
    #400000;
    mismatches++;
    test_done();
  end
endmodule // test_usbh_top

bind usbh_top usbh_top_monitor mon (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc_i),
  .wb_stb_i(wb_stb_i), .wb_ack_o(wb_ack_o), .dp_i(dp_i), .dm_i(dm_i),
  .host_run_o(host_run_o), .attached_o(attached_o), .full_speed_o(full_speed_o),
  .lnk_tx_ready_i(lnk_tx_ready_i), .lnk_tx_valid_o(lnk_tx_valid_o),
  .lnk_tx_data_o(lnk_tx_data_o));
